// ==== core/afs_ctrl.v ====
`timescale 1ns/1ps
`include "afs_regs.vh"

module afs_ctrl
(
    mclk,
    rst_b,
    reg_wr,
    reg_rd,
    reg_addr,
    reg_wdata,
    reg_rdata,
    gen_pin,
    fb_fixed_point_term,
    fb_remainder_form,
    use_frac_out_divider,
    frac_out_div_value,
    fb_divide_out,
    frac_div_out,
    frac_div_commit,
    spread_active
);
    input  wire        mclk;                  // 200 mhz clock
    input  wire        rst_b;                 // async reset, active low
    input  wire        reg_wr;                // byte register write strobe
    input  wire        reg_rd;                // byte register read strobe
    input  wire [15:0] reg_addr;              // register offset
    input  wire [7:0]  reg_wdata;             // write data
    output reg  [7:0]  reg_rdata;             // read data, one cycle after strobe
    input  wire [3:0]  gen_pin;               // general pins 0..3
    input  wire [41:0] fb_fixed_point_term;   // nominal feedback term, 9.33
    input  wire        fb_remainder_form;     // divide is term + rem/den
    input  wire        use_frac_out_divider;  // modulate fractional divider
    input  wire [39:0] frac_out_div_value;    // nominal fractional divider, 4.36
    output reg  [41:0] fb_divide_out;         // effective feedback divide value
    output reg  [39:0] frac_div_out;          // effective fractional divider value
    output reg         frac_div_commit;       // pulse: last value byte written
    output reg         spread_active;         // spread sequencer out of SP_IDLE

    // ------------------------------------------------------------------------
    // state encodings
    // ------------------------------------------------------------------------
    localparam [1:0] SP_IDLE  = 2'b00;        // no modulation
    localparam [1:0] SP_DOWN1 = 2'b01;        // first falling ramp
    localparam [1:0] SP_UP    = 2'b10;        // rising ramp
    localparam [1:0] SP_DOWN2 = 2'b11;        // closing ramp (centre only)

    // ------------------------------------------------------------------------
    // registers and signals
    // ------------------------------------------------------------------------
    reg  [7:0]  trunc_q;                      // truncate position
    reg  [7:0]  stepcfg_q;                    // step source config
    reg  [7:0]  sprcfg_q;                     // spread config
    reg  [15:0] scnt_q;                       // spread count
    reg  [31:0] step_q;                       // step value
    reg  [7:0]  fodctl_q;                     // fractional divider control
    reg  [3:0]  pin_m_q;                      // synchroniser first stage
    reg  [3:0]  pin_s_q;                      // synchroniser second stage
    reg         inc_prev_q;                   // previous increment level
    reg         dec_prev_q;                   // previous decrement level
    reg         en_prev_q;                    // spread enable, registered
    reg  [47:0] adj_q;                        // accumulated inc/dec offset
    reg  [47:0] sofs_q;                       // spread offset
    reg  [1:0]  sp_state_q;                   // spread phase
    reg  [16:0] sp_cnt_q;                     // spread ticks left in phase
    reg  [1:0]  pre_q;                        // spread clock prescaler
    reg  [1:0]  sp_state_d;
    reg  [16:0] sp_cnt_d;
    reg  [47:0] sofs_d;
    reg  [47:0] fb_sum;
    reg  [47:0] fd_sum;
    reg  [7:0]  rdata_d;
    wire        inc_lvl;
    wire        dec_lvl;
    wire        en_lvl;
    wire        sp_tick;
    wire [47:0] step_edge;
    wire [47:0] step_full;
    wire        fd_mod;

    // ------------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------------
    // source select: 000 software bit, 001..100 pins, unused codes read low
    function src_sel;
        input [2:0] sel;
        input       swbit;
        input [3:0] pins;
        begin
            case (sel)
                3'h0:    src_sel = swbit;
                3'h1:    src_sel = pins[0];
                3'h2:    src_sel = pins[1];
                3'h3:    src_sel = pins[2];
                3'h4:    src_sel = pins[3];
                default: src_sel = 1'b0;
            endcase
        end
    endfunction

    // clears the low tp fraction bits; values above 33 are treated as 33
    function [41:0] trunc_mask;
        input [7:0] tp;
        integer i;
        begin
            trunc_mask = {42{1'b1}};
            for (i = 0; i < `AFS_FRAC_BITS; i = i + 1)
                if (i < tp)
                    trunc_mask[i] = 1'b0;
        end
    endfunction

    // ------------------------------------------------------------------------
    // source selection and edge detection
    // ------------------------------------------------------------------------
    assign dec_lvl = src_sel(stepcfg_q[`AFS_SC_DSEL_HI:`AFS_SC_DSEL_LO],
                             stepcfg_q[`AFS_SC_DEC_BIT], pin_s_q);
    assign inc_lvl = src_sel(stepcfg_q[`AFS_SC_ISEL_HI:`AFS_SC_ISEL_LO],
                             stepcfg_q[`AFS_SC_INC_BIT], pin_s_q);
    assign en_lvl  = src_sel(sprcfg_q[`AFS_SP_ESEL_HI:`AFS_SP_ESEL_LO],
                             sprcfg_q[`AFS_SP_EN_BIT], pin_s_q);

    // only the low 24 step bits, placed 7 up, move the feedback divider on inc/dec edges
    assign step_edge = {17'h0, step_q[23:0], 7'h0};
    assign step_full = {16'h0, step_q};

    // spread on the fractional divider needs its mode set to spread
    assign fd_mod = use_frac_out_divider &
                    (fodctl_q[`AFS_FC_MODE_HI:`AFS_FC_MODE_LO] == `AFS_MODE_SPREAD);

    // prescaler only divides when use_frac_out_divider is set
    assign sp_tick = ~use_frac_out_divider |
                     (pre_q == sprcfg_q[`AFS_SP_CDIV_HI:`AFS_SP_CDIV_LO]);

    // ------------------------------------------------------------------------
    // register file writes
    // ------------------------------------------------------------------------
    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            trunc_q   <= `AFS_RST_ZERO;
            stepcfg_q <= `AFS_RST_ZERO;
            sprcfg_q  <= `AFS_RST_ZERO;
            scnt_q    <= {2{`AFS_RST_ZERO}};
            step_q    <= {4{`AFS_RST_ZERO}};
            fodctl_q  <= `AFS_RST_FODCTL;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `AFS_OFS_TRUNC:   trunc_q        <= reg_wdata;
                `AFS_OFS_STEPCFG: stepcfg_q      <= reg_wdata;
                `AFS_OFS_SPRCFG:  sprcfg_q       <= {1'b0, reg_wdata[6:0]};
                `AFS_OFS_SCNT_LO: scnt_q[7:0]    <= reg_wdata;
                `AFS_OFS_SCNT_HI: scnt_q[15:8]   <= reg_wdata;
                `AFS_OFS_STEP0:   step_q[7:0]    <= reg_wdata;
                `AFS_OFS_STEP1:   step_q[15:8]   <= reg_wdata;
                `AFS_OFS_STEP2:   step_q[23:16]  <= reg_wdata;
                `AFS_OFS_STEP3:   step_q[31:24]  <= reg_wdata;
                `AFS_OFS_FODCTL:  fodctl_q       <= {reg_wdata[7:4], 1'b0, reg_wdata[2:0]};
                default:          trunc_q        <= trunc_q; // unmapped: ignored
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // read mux; unmapped offsets read zero
    // ------------------------------------------------------------------------
    always @*
    begin
        case (reg_addr)
            `AFS_OFS_TRUNC:   rdata_d = trunc_q;
            `AFS_OFS_STEPCFG: rdata_d = stepcfg_q;
            `AFS_OFS_SPRCFG:  rdata_d = sprcfg_q;
            `AFS_OFS_SCNT_LO: rdata_d = scnt_q[7:0];
            `AFS_OFS_SCNT_HI: rdata_d = scnt_q[15:8];
            `AFS_OFS_STEP0:   rdata_d = step_q[7:0];
            `AFS_OFS_STEP1:   rdata_d = step_q[15:8];
            `AFS_OFS_STEP2:   rdata_d = step_q[23:16];
            `AFS_OFS_STEP3:   rdata_d = step_q[31:24];
            `AFS_OFS_FODCTL:  rdata_d = fodctl_q;
            default:          rdata_d = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------------
    // pin synchroniser, edge history and step accumulator
    // ------------------------------------------------------------------------
    // a toggle on either edge counts once; both at once cancel out
    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_m_q    <= 4'h0;
            pin_s_q    <= 4'h0;
            inc_prev_q <= 1'b0;
            dec_prev_q <= 1'b0;
            en_prev_q  <= 1'b0;
            adj_q      <= 48'h0;
        end
        else
        begin
            pin_m_q    <= gen_pin;
            pin_s_q    <= pin_m_q;
            inc_prev_q <= inc_lvl;
            dec_prev_q <= dec_lvl;
            en_prev_q  <= en_lvl;
            adj_q      <= adj_q + ((inc_lvl ^ inc_prev_q) ? step_edge : 48'h0)
                                - ((dec_lvl ^ dec_prev_q) ? step_edge : 48'h0);
        end
    end

    // ------------------------------------------------------------------------
    // spread sequencer: down first, then up, repeated while enabled
    // ------------------------------------------------------------------------
    always @*
    begin
        sp_state_d = sp_state_q;
        sp_cnt_d   = sp_cnt_q;
        sofs_d     = sofs_q;
        if (!en_prev_q || scnt_q == 16'h0000)
        begin
            sp_state_d = SP_IDLE;
            sp_cnt_d   = 17'h0;
            sofs_d     = 48'h0;
        end
        else if (sp_tick)
        begin
            case (sp_state_q)
                SP_IDLE:
                begin
                    sp_state_d = SP_DOWN1;
                    sp_cnt_d   = {1'b0, scnt_q} - 17'h1;
                    sofs_d     = sofs_q - step_full;
                end
                SP_DOWN1, SP_DOWN2:
                begin
                    sofs_d = sofs_q - step_full;
                    if (sp_cnt_q == 17'h0)
                    begin
                        // after the closing ramp hits zero, centre spread keeps falling
                        sofs_d     = (sp_state_q == SP_DOWN2) ? (sofs_q - step_full) :
                                     (sofs_q + step_full);
                        sp_state_d = (sp_state_q == SP_DOWN2) ? SP_DOWN1 : SP_UP;
                        // centre spread climbs twice as far to cross zero
                        sp_cnt_d   = (sprcfg_q[`AFS_SP_DOWN_BIT] || sp_state_q == SP_DOWN2) ?
                                     ({1'b0, scnt_q} - 17'h1) :
                                     ({scnt_q, 1'b0} - 17'h1);
                    end
                    else
                        sp_cnt_d = sp_cnt_q - 17'h1;
                end
                SP_UP:
                begin
                    sofs_d = sofs_q + step_full;
                    if (sp_cnt_q == 17'h0)
                    begin
                        sofs_d     = sofs_q - step_full;
                        sp_state_d = sprcfg_q[`AFS_SP_DOWN_BIT] ? SP_DOWN1 : SP_DOWN2;
                        sp_cnt_d   = {1'b0, scnt_q} - 17'h1;
                    end
                    else
                        sp_cnt_d = sp_cnt_q - 17'h1;
                end
                default:
                begin
                    sp_state_d = SP_IDLE;
                    sofs_d     = 48'h0;
                end
            endcase
        end
    end

    // centre spread: the closing down ramp lands back at zero, then repeats
    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sp_state_q <= SP_IDLE;
            sp_cnt_q   <= 17'h0;
            sofs_q     <= 48'h0;
            pre_q      <= 2'h0;
        end
        else
        begin
            sp_state_q <= sp_state_d;
            sp_cnt_q   <= sp_cnt_d;
            sofs_q     <= sofs_d;
            pre_q      <= sp_tick ? 2'h0 : pre_q + 2'h1;
        end
    end

    // ------------------------------------------------------------------------
    // effective divide values
    // ------------------------------------------------------------------------
    always @*
    begin
        fb_sum = {6'h0, fb_fixed_point_term} + adj_q
                 + (use_frac_out_divider ? 48'h0 : sofs_q);
        fd_sum = {8'h0, frac_out_div_value} + (fd_mod ? sofs_q : 48'h0);
    end

    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fb_divide_out   <= 42'h0;
            frac_div_out    <= 40'h0;
            frac_div_commit <= 1'b0;
            spread_active   <= 1'b0;
            reg_rdata       <= 8'h00;
        end
        else
        begin
            // truncation only matters in the remainder form
            fb_divide_out   <= fb_remainder_form ?
                               (fb_sum[41:0] & trunc_mask(trunc_q)) : fb_sum[41:0];
            frac_div_out    <= fd_sum[39:0];
            frac_div_commit <= reg_wr && (reg_addr == (`AFS_FOD_VAL_BASE + 16'h1 +
                               {13'h0, fodctl_q[`AFS_FC_WLEN_HI:`AFS_FC_WLEN_LO]}));
            spread_active   <= (sp_state_d != SP_IDLE);
            reg_rdata       <= reg_rd ? rdata_d : 8'h00;
        end
    end

endmodule // afs_ctrl

// ==== core/afs_regs.vh ====
`ifndef AFS_REGS_VH
`define AFS_REGS_VH

// ----------------------------------------------------------------------------
// register offsets (byte registers)
// ----------------------------------------------------------------------------
`define AFS_OFS_TRUNC      16'h0114
`define AFS_OFS_STEPCFG    16'h0115
`define AFS_OFS_SPRCFG     16'h0116
`define AFS_OFS_SCNT_LO    16'h0117
`define AFS_OFS_SCNT_HI    16'h0118
`define AFS_OFS_STEP0      16'h0119
`define AFS_OFS_STEP1      16'h011a
`define AFS_OFS_STEP2      16'h011b
`define AFS_OFS_STEP3      16'h011c
`define AFS_OFS_FODCTL     16'h0140

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define AFS_RST_ZERO       8'h00
`define AFS_RST_FODCTL     8'h04

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define AFS_SC_DEC_BIT     7
`define AFS_SC_DSEL_HI     6
`define AFS_SC_DSEL_LO     4
`define AFS_SC_INC_BIT     3
`define AFS_SC_ISEL_HI     2
`define AFS_SC_ISEL_LO     0
`define AFS_SP_CDIV_HI     6
`define AFS_SP_CDIV_LO     5
`define AFS_SP_DOWN_BIT    4
`define AFS_SP_EN_BIT      3
`define AFS_SP_ESEL_HI     2
`define AFS_SP_ESEL_LO     0
`define AFS_FC_MODE_HI     7
`define AFS_FC_MODE_LO     4
`define AFS_FC_WLEN_HI     2
`define AFS_FC_WLEN_LO     0

// ----------------------------------------------------------------------------
// encodings and numeric constants
// ----------------------------------------------------------------------------
`define AFS_MODE_DIV       4'h0
`define AFS_MODE_SPREAD    4'h1
`define AFS_FRAC_BITS      6'h21
`define AFS_STEP_SHIFT     7
`define AFS_FOD_VAL_BASE   16'h0140

`endif

// ==== verification/afs_ctrl_sva.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port checker for the step and spread control block
// ----------------------------------------------------------------
module afs_ctrl_sva
(
    input wire        mclk,
    input wire        rst_b,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [15:0] reg_addr,
    input wire [7:0]  reg_wdata,
    input wire [7:0]  reg_rdata,
    input wire [3:0]  gen_pin,
    input wire [41:0] fb_fixed_point_term,
    input wire        fb_remainder_form,
    input wire        use_frac_out_divider,
    input wire [39:0] frac_out_div_value,
    input wire [41:0] fb_divide_out,
    input wire [39:0] frac_div_out,
    input wire        frac_div_commit,
    input wire        spread_active
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    // read data is only driven in the cycle after a read
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero while idle");
    unmapped_read_a: assert property (reg_rd && (reg_addr < 16'h0114 ||
        (reg_addr > 16'h011c && reg_addr != 16'h0140)) |=> reg_rdata == 8'h00)
        else $error("unmapped read returned data");
    reserved_bit_a: assert property (reg_rd && (reg_addr == 16'h0116 ||
        reg_addr == 16'h0140) |=> (reg_rdata &
        ($past(reg_addr) == 16'h0116 ? 8'h80 : 8'h08)) == 8'h00)
        else $error("reserved bit read as one");
    step_cfg_rw_a: assert property (reg_wr && reg_addr == 16'h0115 ##2
        (reg_rd && reg_addr == 16'h0115) |=> reg_rdata == $past(reg_wdata, 3))
        else $error("step config readback differs");
    // the commit pulse follows a write to one of the value bytes 0x141..0x148
    commit_cause_a: assert property (frac_div_commit |-> $past(reg_wr) &&
        $past(reg_addr) > 16'h0140 && $past(reg_addr) < 16'h0149)
        else $error("commit without value byte write");
    commit_once_a: assert property (frac_div_commit |=> !frac_div_commit || $past(reg_wr))
        else $error("commit pulse longer than one cycle");
    // with no cause in sight the feedback value must not drift
    fb_hold_a: assert property (((!spread_active || use_frac_out_divider) &&
        !reg_wr && $stable(gen_pin) && $stable(fb_fixed_point_term) &&
        $stable(fb_remainder_form) && $stable(use_frac_out_divider))[*7]
        |=> $stable(fb_divide_out))
        else $error("feedback value moved without cause");
    // idle modulation leaves the nominal fractional value untouched
    frac_idle_a: assert property ((!spread_active && $stable(frac_out_div_value))[*4]
        |=> frac_div_out == frac_out_div_value)
        else $error("fractional value offset while idle");
endmodule // afs_ctrl_sva

bind afs_ctrl afs_ctrl_sva u_sva (.mclk(mclk), .rst_b(rst_b), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .gen_pin(gen_pin),
    .fb_fixed_point_term(fb_fixed_point_term), .fb_remainder_form(fb_remainder_form),
    .use_frac_out_divider(use_frac_out_divider), .frac_out_div_value(frac_out_div_value),
    .fb_divide_out(fb_divide_out), .frac_div_out(frac_div_out),
    .frac_div_commit(frac_div_commit), .spread_active(spread_active));

// ==== verification/tb_afs_ctrl.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// self-checking bench for the step and spread control block
// ----------------------------------------------------------------
module tb_afs_ctrl;
    reg          mclk, rst_b, reg_wr, reg_rd, rem_f, use_f;  // clock, reset, controls
    reg  [15:0]  reg_addr;                 // register offset
    reg  [7:0]   reg_wdata;                // write data
    reg  [3:0]   gen_pin;                  // general pins
    reg  [41:0]  term;                     // nominal feedback term
    reg  [39:0]  fval;                     // nominal fractional value
    wire [7:0]   reg_rdata;                // read data
    wire [41:0]  fb_out;                   // effective feedback value
    wire [39:0]  fr_out;                   // effective fractional value
    wire         commit, active;           // commit pulse, modulation flag
    logic [41:0] acc, dlt;                 // step accumulator model, one step
    integer      n_fail, checked, i;
    integer      n_com = 0;                // commit pulses seen

    afs_ctrl uut (.mclk(mclk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .gen_pin(gen_pin), .fb_fixed_point_term(term), .fb_remainder_form(rem_f),
        .use_frac_out_divider(use_f), .frac_out_div_value(fval),
        .fb_divide_out(fb_out), .frac_div_out(fr_out), .frac_div_commit(commit),
        .spread_active(active));

    // ------------------------------------------------------------
    // clock, commit counter, watchdog
    // ------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk)
        if (commit === 1'b1)
            n_com <= n_com + 1;
    // generous bound: the full sequence needs well under 3000 cycles
    initial
    begin
        #50000;
        n_fail = n_fail + 1;
        stop_test;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [41:0] got, input logic [41:0] exp);
    begin
        checked = checked + 1;
        if (got !== exp)
        begin
            n_fail = n_fail + 1;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
    begin
        @(negedge mclk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge mclk);
        reg_wr = 1'b0;
    end
    endtask
    // data is looked at in the single cycle it stands
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
    begin
        @(negedge mclk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge mclk);
        reg_rd = 1'b0;
        chk({34'h0, reg_rdata}, {34'h0, e});
    end
    endtask
    task automatic fb_chk(input logic [41:0] msk);
    begin
        repeat (8) @(negedge mclk);
        chk(fb_out, (term + acc) & msk);
    end
    endtask
    // software bits: up and down give the edges expected on each line
    task automatic sw(input logic [7:0] c, input logic [1:0] up, input logic [1:0] dn);
    begin
        wr(16'h0115, c);
        acc = acc + up * dlt - dn * dlt;
        fb_chk({42{1'b1}});
    end
    endtask
    task automatic pin_step(input integer s, input logic dn);
    begin
        wr(16'h0115, dn ? {1'b0, s[2:0], 4'h0} : {5'h0, s[2:0]});
        repeat (2)
        begin
            @(negedge mclk);
            gen_pin[s-1] = ~gen_pin[s-1];
            acc = dn ? acc - dlt : acc + dlt;
            fb_chk({42{1'b1}});
        end
    end
    endtask
    // spread: count 3, step 0x12345678; amp 0 means no modulation expected
    task automatic spread(input logic dwn, input logic uf, input logic [1:0] dv,
        input logic [2:0] es, input logic amp);
        logic [41:0] base, v, pv, mn, mx;
        integer      nc;
    begin
        use_f = uf;
        base = uf ? {2'h0, fval} : term + acc;
        mn = {42{1'b1}};
        mx = 42'h0;
        nc = 0;
        wr(16'h0116, {1'b0, dv, dwn, es == 3'h0, es});
        if (es != 3'h0)
            gen_pin[es-1] = 1'b1;
        for (i = 0; i < 80; i = i + 1)
        begin
            @(negedge mclk);
            v = uf ? {2'h0, fr_out} : fb_out;
            nc = nc + ((i > 0 && v != pv) ? 1 : 0);
            pv = v;
            mn = (v < mn) ? v : mn;
            mx = (v > mx) ? v : mx;
        end
        chk(mn, amp ? base - 3 * 42'h12345678 : base);
        chk(mx, (amp && !dwn) ? base + 3 * 42'h12345678 : base);
        if (amp)
            chk({41'h0, nc >= 80 / (dv + 1) - 5 && nc <= 80 / (dv + 1) + 1}, 42'h1);
        if (uf)
            chk(fb_out, term + acc);
        chk({41'h0, active}, 42'h1);
        wr(16'h0116, 8'h00);
        gen_pin = 4'h0;
        repeat (8) @(negedge mclk);
        chk(uf ? {2'h0, fr_out} : fb_out, base);
        chk({41'h0, active}, 42'h0);
        use_f = 1'b0;
    end
    endtask

    task stop_test;
    begin
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        {reg_wr, reg_rd, rem_f, use_f, gen_pin, reg_addr, reg_wdata} = 32'h0;
        {n_fail, checked} = 64'h0;
        term = 42'h100_0000_0fff;
        fval = 40'h90_0000_0000;
        acc = 42'h0;
        dlt = {11'h0, 24'h345678, 7'h0};
        rst_b = 1'b0;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        rst_b = 1'b1;
        // reset values, unmapped and reserved places
        for (i = 0; i < 9; i = i + 1)
            rd(16'h0114 + i[15:0], 8'h00);
        rd(16'h0140, 8'h04);
        rd(16'h0120, 8'h00);
        wr(16'h0116, 8'hff);
        rd(16'h0116, 8'h7f);
        wr(16'h0116, 8'h00);
        wr(16'h0140, 8'hff);
        rd(16'h0140, 8'hf7);
        wr(16'h0140, 8'h04);
        wr(16'h0115, 8'h55);
        rd(16'h0115, 8'h55);
        // step value with a nonzero top byte that inc/dec edges must ignore
        for (i = 0; i < 4; i = i + 1)
            wr(16'h0119 + i[15:0], 8'h78 - 8'h22 * i[7:0]);
        use_f = 1'b0;
        sw(8'h08, 2'd1, 2'd0);
        sw(8'h00, 2'd1, 2'd0);
        sw(8'h80, 2'd0, 2'd1);
        sw(8'h88, 2'd1, 2'd0);
        sw(8'h08, 2'd0, 2'd1);
        sw(8'h80, 2'd1, 2'd1);
        sw(8'h00, 2'd0, 2'd1);
        for (i = 1; i < 5; i = i + 1)
        begin
            pin_step(i, 1'b0);
            pin_step(i, 1'b1);
        end
        wr(16'h0115, 8'h55);
        gen_pin = 4'hf;
        fb_chk({42{1'b1}});
        gen_pin = 4'h0;
        fb_chk({42{1'b1}});
        wr(16'h0115, 8'h00);
        // truncation in remainder form only
        rem_f = 1'b1;
        wr(16'h0114, 8'h09);
        fb_chk(~42'h1ff);
        // software zeroes the truncated bits, so nothing is lost
        term = term & ~42'h1ff;
        fb_chk({42{1'b1}});
        wr(16'h0114, 8'h21);
        fb_chk(~42'h1_ffff_ffff);
        wr(16'h0114, 8'h00);
        fb_chk({42{1'b1}});
        rem_f = 1'b0;
        wr(16'h0114, 8'h21);
        fb_chk({42{1'b1}});
        wr(16'h0114, 8'h00);
        // modulation
        wr(16'h0117, 8'h03);
        wr(16'h0118, 8'h00);
        spread(1'b1, 1'b0, 2'd0, 3'd0, 1'b1);
        spread(1'b0, 1'b0, 2'd0, 3'd2, 1'b1);
        spread(1'b1, 1'b1, 2'd2, 3'd0, 1'b0);
        wr(16'h0140, 8'h14);
        spread(1'b0, 1'b1, 2'd2, 3'd4, 1'b1);
        // commit on the last value byte only
        i = n_com;
        wr(16'h0144, 8'h00);
        wr(16'h0145, 8'h00);
        repeat (3) @(negedge mclk);
        chk(n_com - i, 42'h1);
        wr(16'h0140, 8'h02);
        wr(16'h0143, 8'h00);
        repeat (3) @(negedge mclk);
        chk(n_com - i, 42'h2);
        stop_test;
    end
endmodule // tb_afs_ctrl
